//--- rtl/pmc_apb.sv
// pmc_apb: apb slave register file
module pmc_apb
  import pmc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] state_vec,
  output logic mode_wr,
  output logic [1:0] mode_sel,
  output logic [15:0] act_tpl,
  output logic [15:0] alt_tpl,
  output logic [7:0] wake_en,
  output logic [1:0] reg_ctl
);

  logic [15:0] act_r, act_nxt, alt_r, alt_nxt;
  logic [7:0] wake_r, wake_nxt;
  logic [1:0] rc_r, rc_nxt;
  logic [31:0] rd;
  logic hit;
  logic wr;

  assign wr = psel && penable && pwrite && clk_en;
  assign pready = 1'b1;

  always_comb begin
    rd = 32'h0;
    hit = 1'b1;
    if (paddr == PMC_MODE_OFF) begin
      rd = {27'h0, state_vec};
    end else if (paddr == PMC_ACT_TPL_OFF) begin
      rd = {16'h0, act_r};
    end else if (paddr == PMC_ALT_TPL_OFF) begin
      rd = {16'h0, alt_r};
    end else if (paddr == PMC_WAKE_EN_OFF) begin
      rd = {24'h0, wake_r};
    end else if (paddr == PMC_REG_CTL_OFF) begin
      rd = {30'h0, rc_r};
    end else if (paddr == PMC_STATUS_OFF) begin
      rd = {27'h0, state_vec};
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    act_nxt = act_r;
    alt_nxt = alt_r;
    wake_nxt = wake_r;
    rc_nxt = rc_r;
    if (wr && paddr == PMC_ACT_TPL_OFF) begin
      act_nxt = pwdata[15:0];
    end else if (wr && paddr == PMC_ALT_TPL_OFF) begin
      alt_nxt = pwdata[15:0];
    end else if (wr && paddr == PMC_WAKE_EN_OFF) begin
      wake_nxt = pwdata[7:0];
    end else if (wr && paddr == PMC_REG_CTL_OFF) begin
      rc_nxt = pwdata[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      act_r <= PMC_ACT_TPL_RST;
      alt_r <= PMC_ALT_TPL_RST;
      wake_r <= PMC_WAKE_EN_RST;
      rc_r <= PMC_REG_CTL_RST;
    end else if (clk_en) begin
      act_r <= act_nxt;
      alt_r <= alt_nxt;
      wake_r <= wake_nxt;
      rc_r <= rc_nxt;
    end
  end

  assign prdata = (psel && !pwrite) ? rd : 32'h0;
  assign pslverr = psel && penable && !hit;
  assign mode_wr = wr && paddr == PMC_MODE_OFF;
  assign mode_sel = pwdata[1:0];
  assign act_tpl = act_r;
  assign alt_tpl = alt_r;
  assign wake_en = wake_r;
  assign reg_ctl = rc_r;

endmodule : pmc_apb

//--- rtl/pmc_pkg.sv
// pmc_pkg: constants and types for the power mode controller
package pmc_pkg;

  // ******************************
  // register byte offsets
  // ******************************
  localparam logic [7:0] PMC_MODE_OFF = 8'h00;
  localparam logic [7:0] PMC_ACT_TPL_OFF = 8'h04;
  localparam logic [7:0] PMC_ALT_TPL_OFF = 8'h08;
  localparam logic [7:0] PMC_WAKE_EN_OFF = 8'h0C;
  localparam logic [7:0] PMC_REG_CTL_OFF = 8'h10;
  localparam logic [7:0] PMC_STATUS_OFF = 8'h14;

  // ******************************
  // widths, fields and reset values
  // ******************************
  localparam int PMC_NSUB = 16;
  localparam int PMC_NWAKE = 8;
  localparam int PMC_CPU_BIT = 0;
  localparam int PMC_PIN_WAKE_BIT = 0;
  localparam int PMC_REG_DIG_BIT = 0;
  localparam int PMC_REG_ANA_BIT = 1;
  localparam logic [15:0] PMC_ACT_TPL_RST = 16'hFFFF;
  localparam logic [15:0] PMC_ALT_TPL_RST = 16'hFFFE;
  localparam logic [7:0] PMC_WAKE_EN_RST = 8'hFF;
  localparam logic [1:0] PMC_REG_CTL_RST = 2'h0;

  // ******************************
  // mode-select codes
  // ******************************
  localparam logic [1:0] PMC_SEL_ACTIVE = 2'h0;
  localparam logic [1:0] PMC_SEL_ALT = 2'h1;
  localparam logic [1:0] PMC_SEL_SLEEP = 2'h2;
  localparam logic [1:0] PMC_SEL_HIB = 2'h3;

  // ******************************
  // timing
  // ******************************
  localparam int PMC_CLK_HZ = 20000000;
  localparam int PMC_RESUME_US = 15;
  localparam int PMC_RESUME_CYC = (PMC_RESUME_US * (PMC_CLK_HZ / 1000000) > 0) ?
                                  PMC_RESUME_US * (PMC_CLK_HZ / 1000000) : 1;
  localparam int PMC_CNT_W = 9;

  typedef enum logic [4:0] {
    PMC_ST_ACTIVE = 5'h01,
    PMC_ST_ALT = 5'h02,
    PMC_ST_SLEEP = 5'h04,
    PMC_ST_HIB = 5'h08,
    PMC_ST_RESUME = 5'h10
  } pmc_state_t;

endpackage : pmc_pkg

//--- rtl/pmc_sync.sv
// pmc_sync: three-stage synchroniser with agreement filter
module pmc_sync
  import pmc_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s2_r[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else if (clk_en) begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;

endmodule : pmc_sync

//--- rtl/pmc_top.sv
// pmc_top: global power mode controller
// Operation
// - four modes active, alternate active, sleep and hibernate, highest to lowest power.
// - in active each subsystem enable follows its bit of the active template.
// - alternate active uses its own separately written template.
// - entering sleep forces every subsystem off whatever the templates say.
// - low-speed oscillators and timewheel stay running through sleep.
// - core regulators run buzzed during sleep.
// - hibernate stops every clock while registers and sram keep their contents.
// - only pin interrupts wake from hibernate.
// - in hibernate only the hibernate regulator is enabled.
// - core regulators may be disabled for external regulation in active, alternate and sleep.
// - any wakeup returns to active and re-enables the cpu regardless of template; the code holds cpu_en on for one cycle, then it follows act_tpl bit 0.
// - after reset the mode is active.
// - resume from sleep takes no more than 15 us.
module pmc_top
  import pmc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PMC_NWAKE-1:0] wake_irq,
  output logic [PMC_NSUB-1:0] subsys_en,
  output logic cpu_en,
  output logic sys_clk_en,
  output logic low_speed_osc_en,
  output logic dig_reg_en,
  output logic ana_reg_en,
  output logic core_reg_buzz,
  output logic hib_reg_en,
  output logic retain
);

  // ******************************
  // wiring
  // ******************************
  pmc_state_t st_r, st_nxt;
  logic [PMC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [PMC_NWAKE-1:0] wake_s;
  logic mode_wr;
  logic [1:0] mode_sel;
  logic [15:0] act_tpl, alt_tpl;
  logic [7:0] wake_en;
  logic [1:0] reg_ctl;
  logic any_wake, pin_wake;
  logic [PMC_NSUB-1:0] sub_r, sub_nxt;
  logic cpu_r, cpu_nxt, clk_r, clk_nxt, lso_r, lso_nxt;
  logic dig_r, dig_nxt, ana_r, ana_nxt, buzz_r, buzz_nxt, hib_r, hib_nxt;

  pmc_sync #(.W(PMC_NWAKE)) pmc_sync_i (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .async_in(wake_irq),
    .sync_out(wake_s)
  );

  pmc_apb pmc_apb_i (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .state_vec(st_r),
    .mode_wr(mode_wr),
    .mode_sel(mode_sel),
    .act_tpl(act_tpl),
    .alt_tpl(alt_tpl),
    .wake_en(wake_en),
    .reg_ctl(reg_ctl)
  );

  assign any_wake = |(wake_s & wake_en);
  assign pin_wake = wake_s[PMC_PIN_WAKE_BIT] & wake_en[PMC_PIN_WAKE_BIT];

  // ******************************
  // mode state machine
  // ******************************
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      PMC_ST_ACTIVE, PMC_ST_ALT: begin
        if (mode_wr) begin
          case (mode_sel)
            PMC_SEL_ALT: st_nxt = PMC_ST_ALT;
            PMC_SEL_SLEEP: st_nxt = PMC_ST_SLEEP;
            PMC_SEL_HIB: st_nxt = PMC_ST_HIB;
            default: st_nxt = PMC_ST_ACTIVE;
          endcase
        end else if (st_r == PMC_ST_ALT && any_wake) begin
          st_nxt = PMC_ST_ACTIVE;
        end
      end
      PMC_ST_SLEEP: begin
        if (any_wake) begin
          st_nxt = PMC_ST_RESUME;
          cnt_nxt = PMC_CNT_W'(PMC_RESUME_CYC - 1);
        end
      end
      PMC_ST_HIB: begin
        if (pin_wake) begin
          st_nxt = PMC_ST_ACTIVE;
        end
      end
      PMC_ST_RESUME: begin
        if (cnt_r == '0) begin
          st_nxt = PMC_ST_ACTIVE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: st_nxt = PMC_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= PMC_ST_ACTIVE;
      cnt_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ******************************
  // enable outputs
  // ******************************
  always_comb begin
    sub_nxt = '0;
    cpu_nxt = 1'b0;
    clk_nxt = 1'b0;
    lso_nxt = 1'b0;
    dig_nxt = 1'b0;
    ana_nxt = 1'b0;
    buzz_nxt = 1'b0;
    hib_nxt = 1'b0;
    case (st_nxt)
      PMC_ST_ACTIVE: begin
        sub_nxt = act_tpl;
        cpu_nxt = act_tpl[PMC_CPU_BIT] | (st_r != PMC_ST_ACTIVE);
        clk_nxt = 1'b1;
        lso_nxt = 1'b1;
        dig_nxt = ~reg_ctl[PMC_REG_DIG_BIT];
        ana_nxt = ~reg_ctl[PMC_REG_ANA_BIT];
      end
      PMC_ST_ALT: begin
        sub_nxt = alt_tpl;
        cpu_nxt = alt_tpl[PMC_CPU_BIT];
        clk_nxt = 1'b1;
        lso_nxt = 1'b1;
        dig_nxt = ~reg_ctl[PMC_REG_DIG_BIT];
        ana_nxt = ~reg_ctl[PMC_REG_ANA_BIT];
      end
      PMC_ST_SLEEP, PMC_ST_RESUME: begin
        lso_nxt = 1'b1;
        dig_nxt = ~reg_ctl[PMC_REG_DIG_BIT];
        ana_nxt = ~reg_ctl[PMC_REG_ANA_BIT];
        buzz_nxt = (st_nxt == PMC_ST_SLEEP);
      end
      PMC_ST_HIB: begin
        hib_nxt = 1'b1;
      end
      default: begin
        sub_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sub_r <= PMC_ACT_TPL_RST;
      cpu_r <= 1'b1;
      clk_r <= 1'b1;
      lso_r <= 1'b1;
      dig_r <= 1'b1;
      ana_r <= 1'b1;
      buzz_r <= 1'b0;
      hib_r <= 1'b0;
    end else if (clk_en) begin
      sub_r <= sub_nxt;
      cpu_r <= cpu_nxt;
      clk_r <= clk_nxt;
      lso_r <= lso_nxt;
      dig_r <= dig_nxt;
      ana_r <= ana_nxt;
      buzz_r <= buzz_nxt;
      hib_r <= hib_nxt;
    end
  end

  assign subsys_en = sub_r;
  assign cpu_en = cpu_r;
  assign sys_clk_en = clk_r;
  assign low_speed_osc_en = lso_r;
  assign dig_reg_en = dig_r;
  assign ana_reg_en = ana_r;
  assign core_reg_buzz = buzz_r;
  assign hib_reg_en = hib_r;
  assign retain = 1'b1;

  // ******************************
  // checks
  // ******************************
  a_one_hot_mode: assert property (@(posedge clock) disable iff (srst) $onehot(st_r))
    else $error("mode state not one-hot");

  a_hib_pin_only: assert property (@(posedge clock) disable iff (srst)
    (st_r == PMC_ST_HIB && clk_en && !pin_wake) |=> st_r == PMC_ST_HIB)
    else $error("hibernate left without pin wake");

  a_hib_outputs: assert property (@(posedge clock) disable iff (srst)
    (st_r == PMC_ST_HIB && $past(st_r) == PMC_ST_HIB) |-> (hib_reg_en && !dig_reg_en && !ana_reg_en && !sys_clk_en))
    else $error("hibernate outputs wrong");

  a_sleep_forced: assert property (@(posedge clock) disable iff (srst)
    (st_r == PMC_ST_SLEEP && clk_en) |=> (subsys_en == '0 && !cpu_en))
    else $error("sleep left subsystems on");

  a_sleep_lso: assert property (@(posedge clock) disable iff (srst)
    (st_r == PMC_ST_SLEEP) |-> (low_speed_osc_en && core_reg_buzz))
    else $error("sleep osc or buzz wrong");

  a_resume_bound: assert property (@(posedge clock) disable iff (srst)
    ($rose(st_r == PMC_ST_RESUME) && clk_en) |-> ##[1:300] (st_r == PMC_ST_ACTIVE || !clk_en))
    else $error("resume too slow");

  a_wake_cpu: assert property (@(posedge clock) disable iff (srst)
    (st_r != PMC_ST_ACTIVE && st_nxt == PMC_ST_ACTIVE && clk_en) |=> cpu_en)
    else $error("cpu not enabled on wake");

  a_active_tpl: assert property (@(posedge clock) disable iff (srst)
    (st_r == PMC_ST_ACTIVE && $past(st_r) == PMC_ST_ACTIVE && $stable(act_tpl) && clk_en && $past(clk_en))
    |-> subsys_en == act_tpl)
    else $error("active template not applied");

  a_alt_entry: assert property (@(posedge clock) disable iff (srst)
    (st_r == PMC_ST_ACTIVE && clk_en && !mode_wr) |=> st_r == PMC_ST_ACTIVE)
    else $error("left active without write");

endmodule : pmc_top

//--- testbench/pmc_top_test.sv
// pmc_top_test: self-checking bench for the power mode controller
module pmc_top_test
  import pmc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, srst, clk_en, psel, penable, pwrite, pready, pslverr, retain;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [PMC_NWAKE-1:0] wake_irq;
  logic [PMC_NSUB-1:0] subsys_en;
  logic cpu_en, sys_clk_en, low_speed_osc_en, dig_reg_en, ana_reg_en, core_reg_buzz, hib_reg_en, er;
  int failures, tests_run, seed, n;
  logic [15:0] act, alt;
  logic [1:0] rc;

  pmc_top pmc_top_i (.clock(clock), .srst(srst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_irq(wake_irq), .subsys_en(subsys_en), .cpu_en(cpu_en), .sys_clk_en(sys_clk_en),
    .low_speed_osc_en(low_speed_osc_en), .dig_reg_en(dig_reg_en), .ana_reg_en(ana_reg_en),
    .core_reg_buzz(core_reg_buzz), .hib_reg_en(hib_reg_en), .retain(retain));

  always #25 clock = ~clock;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] st_exp(input logic [1:0] code);
    return 32'h1 << code;
  endfunction : st_exp

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wt(input int c);
    repeat (c) @(posedge clock);
    @(negedge clock);
  endtask : wt

  task automatic wake(input logic [7:0] v);
    @(posedge clock);
    wake_irq <= v;
  endtask : wake

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clock = 0; srst = 1; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; wake_irq = 8'h00; failures = 0; tests_run = 0; seed = 28;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    wt(1);
    chk({sys_clk_en, cpu_en, subsys_en}, 32'h3FFFF, "reset outputs");
    chk({low_speed_osc_en, dig_reg_en, ana_reg_en, core_reg_buzz, hib_reg_en}, 32'h1C, "reset regs");
    apb(0, PMC_STATUS_OFF, 0); chk(rd, 32'h01, "status active");
    apb(0, PMC_ACT_TPL_OFF, 0); chk(rd, 32'hFFFF, "act tpl reset");
    apb(0, PMC_ALT_TPL_OFF, 0); chk(rd, 32'hFFFE, "alt tpl reset");
    apb(0, PMC_WAKE_EN_OFF, 0); chk(rd, 32'hFF, "wake en reset");
    apb(0, 8'h3C, 0); chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    for (int i = 0; i < 3; i++) begin
      act = $random(seed) | 16'h0001;
      alt = $random(seed) & 16'hFFFE;
      rc = $random(seed);
      apb(1, PMC_ACT_TPL_OFF, {16'h0, act});
      apb(1, PMC_ALT_TPL_OFF, {16'h0, alt});
      apb(1, PMC_REG_CTL_OFF, {30'h0, rc});
      wt(2);
      chk(subsys_en, act, "active template");
      chk({dig_reg_en, ana_reg_en}, {~rc[0], ~rc[1]}, "external regulation");
      apb(1, PMC_MODE_OFF, PMC_SEL_ALT);
      wt(2);
      chk({cpu_en, subsys_en}, {1'b0, alt}, "alt template");
      apb(0, PMC_STATUS_OFF, 0); chk(rd, st_exp(PMC_SEL_ALT), "status alt");
      wake(8'h01 << (1 + i));
      wt(10);
      chk({cpu_en, subsys_en}, {1'b1, act}, "wake from alt");
      wake(8'h00);
      wt(8);
      apb(1, PMC_MODE_OFF, PMC_SEL_SLEEP);
      wt(2);
      chk({sys_clk_en, low_speed_osc_en, core_reg_buzz, hib_reg_en}, 32'h6, "sleep outputs");
      chk({dig_reg_en, ana_reg_en}, {~rc[0], ~rc[1]}, "sleep ext regulation");
      wake(8'h80 >> i);
      n = 0;
      while (sys_clk_en !== 1'b1 && n < 400) begin
        @(negedge clock);
        n++;
      end
      chk(n > 8 && n <= PMC_RESUME_CYC + 8, 1, "resume time");
      chk(cpu_en, 1'b1, "cpu after sleep");
      wake(8'h00);
      wt(8);
    end
    apb(1, PMC_REG_CTL_OFF, 0);
    apb(1, PMC_MODE_OFF, PMC_SEL_HIB);
    wt(2);
    chk({sys_clk_en, low_speed_osc_en, dig_reg_en, ana_reg_en, hib_reg_en, retain}, 32'h3, "hib outputs");
    wake(8'hFE);
    wt(20);
    chk(hib_reg_en, 1'b1, "non-pin wake ignored");
    wake(8'hFF);
    wt(10);
    chk({hib_reg_en, sys_clk_en, cpu_en}, 32'h3, "pin wake");
    apb(0, PMC_ACT_TPL_OFF, 0); chk(rd, {16'h0, act}, "template retained");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    finish_test();
  end

endmodule : pmc_top_test
